/* File: src/acsc_cfg.svh */
// Purpose: constants of the clock, reset and sync control block
// Assumes: 25 MHz system clock
// Notes: definitions only
`ifndef ACSC_CFG_SVH
`define ACSC_CFG_SVH
`define ACSC_CLK_HZ 25000000
`define ACSC_QUAL_MIN_KHZ 250
`define ACSC_QUAL_CYC 8'((`ACSC_CLK_HZ) / ((`ACSC_QUAL_MIN_KHZ) * 1000))
`define ACSC_INIT_CYC 8'h40
`define ACSC_MOD_DIV_HR 4'h4
`define ACSC_MOD_DIV_LP 4'h8
`define ACSC_BASE_HR 8'h80
`define ACSC_BASE_LP 8'h40
`define ACSC_MODE_LP_FIRST 4'hB
`define ACSC_OFS_CTRL 4'h0
`define ACSC_OFS_CFG2 4'h4
`define ACSC_OFS_DECIM 4'h8
`define ACSC_OFS_STAT 4'hC
`define ACSC_CTRL_LP 0
`define ACSC_CTRL_QDIS 1
`define ACSC_CTRL_REFEN 2
`define ACSC_CTRL_BUF_LO 3
`define ACSC_CTRL_BUF_HI 4
`define ACSC_CTRL_OUTPUT_DATA_CLOCK_LO 8
`define ACSC_CTRL_OUTPUT_DATA_CLOCK_HI 10
`define ACSC_CFG2_SYNC 0
`define ACSC_CTRL_RST 32'h0000_0010
`define ACSC_DECIM_RST 16'h0400
`define ACSC_PIN_W 13
`define ACSC_PIN_IDLE 13'h000C
`endif

/* File: src/acsc_pkg.sv */
// Purpose: types of the clock, reset and sync control block
// Assumes: nothing
// Notes: pin struct order matches the synchroniser vector
package acsc_pkg;
    typedef enum logic [1:0] {BUF_ENABLED, BUF_BYPASS, BUF_PRECHARGE} acsc_buf_mode_t;
    typedef enum logic {ST_INIT, ST_RUN} acsc_state_t;
    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } acsc_avs_req_t;
    typedef struct packed {
        logic [3:0] mode;
        logic [2:0] output_data_clock_sel;
        logic pin_mode;
        logic clk_sel;
        logic start_n;
        logic sync_in_n;
        logic xtal;
        logic mclk;
    } acsc_pins_t;
    typedef struct packed {
        logic int_en;
        logic buf_en;
        logic direct_en;
    } acsc_ref_t;
endpackage

/* File: src/acsc_sync3.sv */
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clk_sys
// Notes: a change is taken once stages two and three agree
`timescale 1ns/10ps
`include "acsc_cfg.svh"
module acsc_sync3
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Pins
    input wire logic [`ACSC_PIN_W-1:0] pin_raw,
    output logic [`ACSC_PIN_W-1:0] pin_q
);
    logic [`ACSC_PIN_W-1:0] s1;
    logic [`ACSC_PIN_W-1:0] s2;
    logic [`ACSC_PIN_W-1:0] s3;
    // Idle level per bit, so every stage leaves reset at its pin's rest value
    localparam logic [`ACSC_PIN_W-1:0] pin_idle = `ACSC_PIN_IDLE;
    genvar i;
    generate
        for (i = 0; i < `ACSC_PIN_W; i = i + 1)
        begin : g_bit
            always_ff @(posedge clk_sys)
            begin
                if (sys_rst)
                begin
                    s1[i] <= pin_idle[i];
                    s2[i] <= pin_idle[i];
                    s3[i] <= pin_idle[i];
                    pin_q[i] <= pin_idle[i];
                end
                else
                begin
                    s1[i] <= pin_raw[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    // Only agreeing later stages count, a lone glitch is dropped
                    if (s2[i] == s3[i])
                        pin_q[i] <= s3[i];
                end
            end
        end
    endgenerate
endmodule // acsc_sync3

/* File: src/acsc_ctrl.sv */
// Purpose: clock derivation, sync pulse and reference buffer control
// Assumes: master clock well below clk_sys; Avalon-MM slave, one wait state
// Notes: pins are sampled, so the derived clocks carry clk_sys jitter
`timescale 1ns/10ps
`include "acsc_cfg.svh"
module acsc_ctrl
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Pins from the board
    input wire acsc_pkg::acsc_pins_t pins_raw,
    // Avalon-MM slave
    input wire acsc_pkg::acsc_avs_req_t avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Derived clocks and sync
    output logic modulator_clock,
    output logic output_data_clock,
    output logic sync_out_n,
    output logic digital_reset,
    // Filter frame strobes
    output logic max_odr_strobe,
    output logic odr_strobe,
    // Reference control
    output acsc_pkg::acsc_ref_t ref_ctl
);
    import acsc_pkg::*;

    logic [`ACSC_PIN_W-1:0] pin_vec;
    acsc_pins_t pins;
    acsc_state_t state;
    logic [7:0] init_cnt;
    logic clk_src;
    logic src_prev;
    logic sync_prev;
    logic start_prev;
    logic [31:0] ctrl;
    logic cfg2_sync;
    logic [15:0] decim;
    logic [3:0] strap_mode;
    logic [2:0] strap_output_data_clock;
    logic [3:0] mod_cnt;
    logic [7:0] output_data_clock_cnt;
    logic [7:0] base_cnt;
    logic [15:0] dec_cnt;
    logic [7:0] miss_cnt;
    logic clk_missing;
    logic sync_req;
    logic src_lvl;
    logic src_edge;
    logic src_rise;
    logic sync_fall;
    logic start_fall;
    logic acc;
    logic wr_go;
    logic cfg2_toggle;
    logic eff_lp;
    logic eff_qdis;
    logic [2:0] eff_output_data_clock;
    logic [15:0] eff_dec;
    logic [3:0] mod_div;
    logic [7:0] output_data_clock_top;
    logic [7:0] base_top;
    logic mod_toggle;
    logic mod_rise;
    acsc_buf_mode_t eff_buf;
    logic [31:0] next_rdata;

    acsc_sync3 u_sync
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_raw(pins_raw),
        .pin_q(pin_vec)
    );
    assign pins = acsc_pins_t'(pin_vec);

    // Decimation of each strap code
    function automatic logic [15:0] pin_decim(input logic [3:0] m);
        case (m)
            4'h0: pin_decim = 16'h0400;
            4'h1, 4'h5, 4'h8, 4'hB: pin_decim = 16'h0200;
            4'h3, 4'h7, 4'hA, 4'hD, 4'hE: pin_decim = 16'h0080;
            default: pin_decim = 16'h0100;
        endcase
    endfunction

    // Strap codes that use the internal reference
    function automatic logic pin_intref(input logic [3:0] m);
        case (m)
            4'h8, 4'h9, 4'hA, 4'hE, 4'hF: pin_intref = 1'b1;
            default: pin_intref = 1'b0;
        endcase
    endfunction

    always_comb
    begin
        src_lvl = clk_src ? pins.xtal : pins.mclk;
        src_edge = (state == ST_RUN) && (src_lvl != src_prev);
        src_rise = src_edge && src_lvl;
        sync_fall = sync_prev && !pins.sync_in_n;
        start_fall = start_prev && !pins.start_n;
        acc = (avs_req.read || avs_req.write) && avs_waitrequest;
        wr_go = avs_req.write && !avs_waitrequest;
        cfg2_toggle = wr_go && (avs_req.address == `ACSC_OFS_CFG2) && avs_req.byteenable[0]
            && (avs_req.writedata[`ACSC_CFG2_SYNC] != cfg2_sync) && !pins.pin_mode;
        eff_lp = pins.pin_mode ? (strap_mode >= `ACSC_MODE_LP_FIRST) : ctrl[`ACSC_CTRL_LP];
        eff_qdis = !pins.pin_mode && ctrl[`ACSC_CTRL_QDIS];
        eff_output_data_clock = pins.pin_mode ? strap_output_data_clock : ctrl[`ACSC_CTRL_OUTPUT_DATA_CLOCK_HI:`ACSC_CTRL_OUTPUT_DATA_CLOCK_LO];
        eff_dec = pins.pin_mode ? pin_decim(strap_mode) : decim;
        eff_buf = acsc_buf_mode_t'(ctrl[`ACSC_CTRL_BUF_HI:`ACSC_CTRL_BUF_LO]);
        mod_div = eff_lp ? `ACSC_MOD_DIV_LP : `ACSC_MOD_DIV_HR;
        output_data_clock_top = (8'h01 << eff_output_data_clock) - 8'h01;
        base_top = eff_lp ? `ACSC_BASE_LP : `ACSC_BASE_HR;
        mod_toggle = src_edge && (mod_cnt == mod_div - 4'h1);
        mod_rise = mod_toggle && !modulator_clock;
        case (avs_req.address)
            `ACSC_OFS_CTRL: next_rdata = ctrl;
            `ACSC_OFS_CFG2: next_rdata = {31'h0, cfg2_sync};
            `ACSC_OFS_DECIM: next_rdata = {16'h0, decim};
            `ACSC_OFS_STAT: next_rdata = {21'h0, strap_output_data_clock, strap_mode, pins.pin_mode,
                clk_missing, clk_src, state == ST_RUN};
            default: next_rdata = 32'h0;
        endcase
    end

    // Init on the internal clock, then latch the source select
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state <= ST_INIT;
            init_cnt <= 8'h0;
            clk_src <= 1'b0;
        end
        else
        begin
            case (state)
                ST_INIT:
                begin
                    init_cnt <= init_cnt + 8'h1;
                    if (init_cnt == `ACSC_INIT_CYC - 8'h1)
                    begin
                        state <= ST_RUN;
                        clk_src <= pins.clk_sel;
                    end
                end
                default:
                    state <= ST_RUN;
            endcase
        end
    end

    // Edge history of sampled pins
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            src_prev <= 1'b0;
            sync_prev <= 1'b1;
            start_prev <= 1'b1;
        end
        else
        begin
            src_prev <= src_lvl;
            sync_prev <= pins.sync_in_n;
            start_prev <= pins.start_n;
        end
    end

    // Avalon-MM slave, one wait state on every access
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end
        else
        begin
            avs_waitrequest <= !acc;
            if (acc)
                avs_readdata <= avs_req.read ? next_rdata : 32'h0;
        end
    end

    // Software registers; a sync pulse leaves them alone
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ctrl <= `ACSC_CTRL_RST;
            cfg2_sync <= 1'b0;
            decim <= `ACSC_DECIM_RST;
        end
        else if (wr_go)
        begin
            case (avs_req.address)
                `ACSC_OFS_CTRL:
                begin
                    if (avs_req.byteenable[0])
                        ctrl[7:0] <= {3'h0, avs_req.writedata[4:0]};
                    if (avs_req.byteenable[1])
                        ctrl[15:8] <= {5'h0, avs_req.writedata[10:8]};
                end
                `ACSC_OFS_CFG2:
                    if (avs_req.byteenable[0])
                        cfg2_sync <= avs_req.writedata[`ACSC_CFG2_SYNC];
                `ACSC_OFS_DECIM:
                begin
                    if (avs_req.byteenable[0])
                        decim[7:0] <= avs_req.writedata[7:0];
                    if (avs_req.byteenable[1])
                        decim[15:8] <= avs_req.writedata[15:8];
                end
                default:
                    cfg2_sync <= cfg2_sync;
            endcase
        end
    end

    // Straps caught after init and on every sync pulse in pin mode
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            strap_mode <= 4'h0;
            strap_output_data_clock <= 3'h0;
        end
        else if ((state == ST_INIT && init_cnt == `ACSC_INIT_CYC - 8'h1)
            || (sync_fall && pins.pin_mode))
        begin
            strap_mode <= pins.mode;
            strap_output_data_clock <= pins.output_data_clock_sel;
        end
    end

    // Digital block reset from the sync input
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            digital_reset <= 1'b0;
        else
            digital_reset <= sync_fall;
    end

    // Modulator and data clock dividers count source transitions
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || digital_reset)
        begin
            mod_cnt <= 4'h0;
            modulator_clock <= 1'b0;
            output_data_clock_cnt <= 8'h0;
            output_data_clock <= 1'b0;
        end
        else if (src_edge)
        begin
            mod_cnt <= mod_toggle ? 4'h0 : mod_cnt + 4'h1;
            if (mod_toggle)
                modulator_clock <= !modulator_clock;
            output_data_clock_cnt <= (output_data_clock_cnt >= output_data_clock_top) ? 8'h0 : output_data_clock_cnt + 8'h1;
            if (output_data_clock_cnt >= output_data_clock_top)
                output_data_clock <= !output_data_clock;
        end
    end

    // Filter frames: base frame at max rate, output frame at chosen rate
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || digital_reset)
        begin
            base_cnt <= 8'h0;
            dec_cnt <= 16'h0;
            max_odr_strobe <= 1'b0;
            odr_strobe <= 1'b0;
        end
        else
        begin
            max_odr_strobe <= mod_rise && (base_cnt == base_top - 8'h1);
            odr_strobe <= mod_rise && (dec_cnt == eff_dec - 16'h1);
            if (mod_rise)
            begin
                base_cnt <= (base_cnt >= base_top - 8'h1) ? 8'h0 : base_cnt + 8'h1;
                dec_cnt <= (dec_cnt >= eff_dec - 16'h1) ? 16'h0 : dec_cnt + 16'h1;
            end
        end
    end

    // Sync output: one master clock period low, launched on a rising edge
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            sync_req <= 1'b0;
            sync_out_n <= 1'b1;
        end
        else
        begin
            if (src_rise)
                sync_out_n <= !(sync_out_n && sync_req);
            // A new request in the launch cycle wins over the clear
            if (start_fall || cfg2_toggle)
                sync_req <= 1'b1;
            else if (src_rise && sync_out_n)
                sync_req <= 1'b0;
        end
    end

    // Clock qualifier: flags a source that stopped toggling
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            miss_cnt <= 8'h0;
            clk_missing <= 1'b0;
        end
        else
        begin
            if (src_edge)
                miss_cnt <= 8'h0;
            else if (miss_cnt < `ACSC_QUAL_CYC)
                miss_cnt <= miss_cnt + 8'h1;
            clk_missing <= (state == ST_RUN) && (miss_cnt >= `ACSC_QUAL_CYC) && !eff_qdis;
        end
    end

    // Reference switches; precharge buffers during the high modulator phase
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            ref_ctl <= '0;
        else
        begin
            ref_ctl.int_en <= pins.pin_mode ? pin_intref(strap_mode) : ctrl[`ACSC_CTRL_REFEN];
            ref_ctl.buf_en <= (eff_buf == BUF_ENABLED)
                || (eff_buf == BUF_PRECHARGE && modulator_clock);
            ref_ctl.direct_en <= (eff_buf == BUF_BYPASS)
                || (eff_buf == BUF_PRECHARGE && !modulator_clock);
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    a_mod_divide:
        assert property ($changed(modulator_clock) && !$past(digital_reset)
            |-> $past(src_edge) && $past(mod_cnt) == $past(mod_div) - 4'h1)
        else $error("modulator clock toggled off its divide count");
    a_init_quiet:
        assert property (state == ST_INIT |-> !src_edge && $stable(modulator_clock))
        else $error("clock activity during register init");
    a_src_select:
        assert property (state == ST_RUN |-> src_lvl == (clk_src ? pins.xtal : pins.mclk))
        else $error("wrong external clock source");
    a_output_data_clock_divide:
        assert property ($changed(output_data_clock) && !$past(digital_reset)
            |-> $past(src_edge) && $past(output_data_clock_cnt) >= $past(output_data_clock_top))
        else $error("data clock toggled off its divide count");
    a_sync_reset:
        assert property (sync_fall && !wr_go |=> digital_reset && $stable(ctrl) ##1 !digital_reset)
        else $error("sync pulse did not reset digital block alone");
    a_start_req:
        assert property (start_fall |=> sync_req)
        else $error("start pulse lost");
    a_sync_out_edge:
        assert property ($changed(sync_out_n) |-> $past(src_rise))
        else $error("sync output moved off a master clock rise");
    a_cfg2_pulse:
        assert property (cfg2_toggle |=> sync_req)
        else $error("config toggle did not request sync");
    a_ref_default:
        assert property ($past(sys_rst) && !pins.pin_mode |-> !ref_ctl.int_en
            && eff_buf == BUF_PRECHARGE)
        else $error("reference defaults wrong after reset");
    a_precharge_phase:
        assert property (!$past(sys_rst) && eff_buf == BUF_PRECHARGE
            && $past(eff_buf == BUF_PRECHARGE)
            |-> ref_ctl.buf_en == $past(modulator_clock) && ref_ctl.direct_en != ref_ctl.buf_en)
        else $error("precharge phase switching wrong");
    a_odr_frame:
        assert property (odr_strobe |-> $past(mod_rise) && $past(dec_cnt) == $past(eff_dec) - 16'h1)
        else $error("output rate strobe off frame");
    a_strap_reread:
        assert property (sync_fall && pins.pin_mode |=> strap_mode == $past(pins.mode))
        else $error("straps not re-read on sync");
    a_start_once:
        assert property (start_fall |=> !start_fall)
        else $error("start assertion gave more than one pulse");
endmodule // acsc_ctrl

/* File: tb/acsc_host_model.sv */
// Purpose: host side of the clock, start and sync pins
// Assumes: driven from the bench clock domain
// Notes: the source is a divided clk_sys, so its edges are clean and exact
`timescale 1ns/10ps
module acsc_host_model
(
    // Clock
    input wire logic clk_sys,
    // Bench control
    input wire logic use_xtal,
    input wire logic [7:0] half_cyc,
    // Pins toward the device
    output logic mclk,
    output logic xtal,
    output logic start_n,
    output logic sync_in_n
);
    logic src = 1'b0;
    logic [7:0] cnt = 8'h00;
    initial
    begin
        start_n = 1'b1;
        sync_in_n = 1'b1;
    end
    // Bench picks half_cyc so the rate stays under the power mode ceiling
    always @(posedge clk_sys)
    begin
        if (cnt >= half_cyc - 8'h01)
        begin
            cnt <= 8'h00;
            src <= ~src;
        end
        else
            cnt <= cnt + 8'h01;
    end
    // Unused clock input is held low, as a tied pin would be
    assign mclk = use_xtal ? 1'b0 : src;
    assign xtal = use_xtal ? src : 1'b0;
    task automatic pulse_start();
        @(posedge clk_sys);
        start_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        start_n <= 1'b1;
    endtask
    // Launched just after a source rise so every device sees one phase
    task automatic pulse_sync();
        @(posedge src);
        @(posedge clk_sys);
        sync_in_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        sync_in_n <= 1'b1;
    endtask
endmodule // acsc_host_model

/* File: tb/tb.sv */
// Purpose: self-checking bench for clock, sync and reference control
// Assumes: master clock comes from acsc_host_model
// Notes: periods are counted in clk_sys cycles at rising edges
`timescale 1ns/10ps
module tb;
    import acsc_pkg::*;
    typedef struct {logic lp; logic [2:0] code; logic [7:0] half; int mod_p; int output_data_clock_p;} acsc_row_t;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic use_xtal = 1'b0;
    logic pin_mode = 1'b0;
    logic [3:0] mode_strap = 4'h0;
    logic [7:0] half_cyc = 8'h02;
    logic mclk, xtal, start_n, host_sync_n, prev_mod;
    acsc_avs_req_t req = '0;
    acsc_pins_t pins;
    acsc_ref_t ref_ctl;
    logic [31:0] avs_readdata, q, v;
    logic avs_waitrequest, modulator_clock, output_data_clock, sync_out_n, digital_reset;
    logic max_odr_strobe, odr_strobe;
    int errors = 0;
    int cmp_count = 0;
    int p, len;
    acsc_row_t rows [4] = '{'{1'b0, 3'h0, 8'h02, 16, 4}, '{1'b0, 3'h3, 8'h02, 16, 32},
        '{1'b1, 3'h1, 8'h04, 64, 16}, '{1'b1, 3'h7, 8'h04, 64, 1024}};
    always #20 clk_sys = ~clk_sys;
    acsc_host_model u_host (.clk_sys(clk_sys), .use_xtal(use_xtal), .half_cyc(half_cyc),
        .mclk(mclk), .xtal(xtal), .start_n(start_n), .sync_in_n(host_sync_n));
    // Sync output looped back to sync input, as on a single device board
    assign pins = '{mode: mode_strap, output_data_clock_sel: 3'h0, pin_mode: pin_mode, clk_sel: use_xtal,
        start_n: start_n, sync_in_n: sync_out_n & host_sync_n, xtal: xtal, mclk: mclk};
    acsc_ctrl u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .pins_raw(pins), .avs_req(req),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .modulator_clock(modulator_clock), .output_data_clock(output_data_clock),
        .sync_out_n(sync_out_n), .digital_reset(digital_reset), .max_odr_strobe(max_odr_strobe),
        .odr_strobe(odr_strobe), .ref_ctl(ref_ctl));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= '{read: !wr, write: wr, address: a, byteenable: 4'hF, writedata: d};
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0 && n < 50)
        begin
            @(posedge clk_sys);
            n++;
        end
        q = avs_readdata;
        req <= '0;
        @(posedge clk_sys);
        if (n == 50)
            errors++;
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return modulator_clock;
            1: return output_data_clock;
            2: return max_odr_strobe;
            3: return odr_strobe;
            4: return !sync_out_n;
            default: return digital_reset;
        endcase
    endfunction
    // Cycles between two rises of the picked signal, 0 if none comes
    task automatic period(input int sel, output int r);
        int t0;
        logic prev;
        t0 = -1;
        prev = 1'b1;
        r = 0;
        for (int n = 0; n < 6000 && r == 0; n++)
        begin
            @(posedge clk_sys);
            if (pick(sel) === 1'b1 && prev === 1'b0)
            begin
                if (t0 >= 0)
                    r = n - t0;
                t0 = n;
            end
            prev = pick(sel);
        end
    endtask
    // Length of the next high phase within 200 cycles
    task automatic pulse(input int sel, output int r);
        r = 0;
        for (int n = 0; n < 200 && !(r > 0 && pick(sel) !== 1'b1); n++)
        begin
            @(posedge clk_sys);
            if (pick(sel) === 1'b1)
                r++;
        end
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
    endtask
    task automatic final_report();
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        final_report();
    end
    initial
    begin
        do_reset();
        len = 0;
        repeat (60)
        begin
            @(posedge clk_sys);
            if (modulator_clock !== 1'b0)
                len++;
        end
        chk("mod_in_init", 0, len);
        chk("int_ref_rst", 0, ref_ctl.int_en);
        bus(0, 4'h0, 0);
        chk("ctrl_rst", 32'h0000_0010, q);
        bus(0, 4'h4, 0);
        chk("cfg2_rst", 0, q);
        bus(0, 4'h8, 0);
        chk("decim_rst", 32'h0000_0400, q);
        bus(0, 4'h2, 0);
        chk("unmapped", 0, q);
        bus(0, 4'hC, 0);
        chk("status_src", 2'b01, q[1:0]);
        foreach (rows[i])
        begin
            half_cyc <= rows[i].half;
            v = {21'h0, rows[i].code, 7'h08, rows[i].lp};
            bus(1, 4'h0, v);
            bus(0, 4'h0, 0);
            chk("ctrl_rb", v, q);
            u_host.pulse_sync();
            period(0, p);
            period(0, p);
            chk("mod_period", rows[i].mod_p, p);
            period(1, p);
            period(1, p);
            chk("output_data_clock_period", rows[i].output_data_clock_p, p);
        end
        prev_mod = modulator_clock;
        len = 0;
        repeat (80)
        begin
            @(posedge clk_sys);
            if (ref_ctl.buf_en !== prev_mod || ref_ctl.direct_en !== !prev_mod)
                len++;
            prev_mod = modulator_clock;
        end
        chk("precharge", 0, len);
        half_cyc <= 8'h02;
        bus(1, 4'h0, 32'h0000_0014);
        bus(1, 4'h8, 32'h0000_0010);
        chk("int_ref_on", 1, ref_ctl.int_en);
        u_host.pulse_sync();
        period(2, p);
        period(2, p);
        chk("max_odr", 2048, p);
        period(3, p);
        period(3, p);
        chk("odr", 256, p);
        fork
            u_host.pulse_start();
            pulse(4, len);
            pulse(5, p);
        join
        chk("start_sync_len", 4, len);
        chk("dig_reset_len", 1, p);
        bus(0, 4'h8, 0);
        chk("decim_kept", 32'h0000_0010, q);
        fork
            bus(1, 4'h4, 32'h0000_0001);
            pulse(4, len);
        join
        chk("cfg2_pulse", 4, len);
        fork
            bus(1, 4'h4, 32'h0000_0001);
            pulse(4, len);
        join
        chk("cfg2_same", 0, len);
        pin_mode <= 1'b1;
        mode_strap <= 4'hB;
        half_cyc <= 8'h04;
        repeat (8) @(posedge clk_sys);
        u_host.pulse_sync();
        period(0, p);
        period(0, p);
        chk("pin_lp_mod", 64, p);
        bus(0, 4'hC, 0);
        chk("strap_status", 5'h17, q[7:3]);
        fork
            bus(1, 4'h4, 32'h0000_0000);
            pulse(4, len);
        join
        chk("cfg2_pin", 0, len);
        use_xtal <= 1'b1;
        pin_mode <= 1'b0;
        half_cyc <= 8'h02;
        do_reset();
        @(posedge clk_sys);
        chk("int_ref_rst2", 0, ref_ctl.int_en);
        bus(0, 4'h0, 0);
        chk("ctrl_rst2", 32'h0000_0010, q);
        repeat (80) @(posedge clk_sys);
        period(0, p);
        period(0, p);
        chk("xtal_mod", 16, p);
        bus(0, 4'hC, 0);
        chk("status_xtal", 2'b11, q[1:0]);
        // Crystal source stops: qualifier flags it until software disables the check
        use_xtal <= 1'b0;
        repeat (120) @(posedge clk_sys);
        bus(0, 4'hC, 0);
        chk("clk_missing", 1, q[2]);
        bus(1, 4'h0, 32'h0000_0012);
        repeat (3) @(posedge clk_sys);
        bus(0, 4'hC, 0);
        chk("qual_disable", 0, q[2]);
        final_report();
    end
endmodule // tb
